/* File: verilog/link_cmd_pkg.sv */
// shared opcodes, frame layout and timing constants for the input link command handler
package link_cmd_pkg;
  localparam int FRAME_W = 8;
  localparam logic [7:0] OP_COLLECT_BASE = 8'h10;
  localparam logic [7:0] OP_COLLECT_LAST = 8'h1F;
  localparam logic [7:0] OP_REG_READ = 8'h06;
  localparam logic [7:0] OP_REG_WRITE = 8'h07;
  localparam logic [7:0] OP_IDENTIFY = 8'h03;
  localparam logic [7:0] OP_NAME = 8'h30;
  localparam logic [7:0] OP_STATUS = 8'h31;
  localparam logic [7:0] OP_EXT_DESCRIBE = 8'h32;
  localparam logic [7:0] OP_UNIQUE_CODE = 8'h33;
  localparam logic [7:0] OP_REPEAT_OFF = 8'h3D;
  localparam logic [7:0] OP_REPEAT_SLOW = 8'h3E;
  localparam logic [7:0] OP_REPEAT_FAST = 8'h3F;
  localparam logic [7:0] OP_STIM_FIRST = 8'h40;
  localparam logic [7:0] OP_STIM_LAST = 8'h46;
  localparam logic [7:0] OP_STIM_GENERAL = 8'h47;
  localparam logic [7:0] OP_RESP_FIRST = 8'h48;
  localparam logic [7:0] OP_RESP_LAST = 8'h4E;
  localparam logic [7:0] OP_REG_ERROR = 8'hFA;
  localparam int REG_TYPE2_BIT = 7;
  localparam logic [7:0] KEY_CURSOR_REPEAT = 8'h02;
  localparam int IDENT_LEN = 1;
  localparam int DESCRIBE_MAX = 10;
  localparam int RECORD_MAX = 15;
  localparam int EXT_DEFINED = 6;
  localparam int COLLECT_MAX = 15;
  localparam longint CLK_HZ = 200000000;
  localparam longint SLOW_REPEAT_HZ = 30;
  localparam longint FAST_REPEAT_HZ = 60;
  localparam longint SLOW_REPEAT_CYC = CLK_HZ / SLOW_REPEAT_HZ;
  localparam longint FAST_REPEAT_CYC = CLK_HZ / FAST_REPEAT_HZ;
  typedef enum logic [1:0] {REPEAT_OFF, REPEAT_SLOW, REPEAT_FAST} repeat_mode_type;
endpackage : link_cmd_pkg

/* File: verilog/link_frame_if.sv */
// frame loop between host link controller and the device command handler
`timescale 1ns/10ps
`default_nettype none
interface link_frame_if;
  logic h2d_valid;
  logic h2d_cmd;
  logic [7:0] h2d_data;
  logic h2d_ready;
  logic d2h_valid;
  logic d2h_cmd;
  logic [7:0] d2h_data;
  logic d2h_ready;
  modport host (output h2d_valid, output h2d_cmd, output h2d_data, input h2d_ready,
    input d2h_valid, input d2h_cmd, input d2h_data, output d2h_ready);
  modport device (input h2d_valid, input h2d_cmd, input h2d_data, output h2d_ready,
    output d2h_valid, output d2h_cmd, output d2h_data, input d2h_ready);
endinterface : link_frame_if
`default_nettype wire

/* File: verilog/input_link_device_cmd_handler.sv */
// device end: decodes command frames, answers with data records and the echoed command
`timescale 1ns/10ps
`default_nettype none
module input_link_device_cmd_handler #(
  parameter int NREG = 16,
  parameter int DESC_LEN = 2,
  parameter int NAME_LEN = 8,
  parameter int STATUS_LEN = 1,
  parameter int EXT_LEN = link_cmd_pkg::EXT_DEFINED,
  parameter int CODE_LEN = 4,
  parameter logic [7:0] DEVICE_ID = 8'h5A, // arbitrary id value
  parameter longint SLOW_CYC = link_cmd_pkg::SLOW_REPEAT_CYC,
  parameter longint FAST_CYC = link_cmd_pkg::FAST_REPEAT_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // frame loop
  link_frame_if.device link,
  // key input from the scanner
  input wire logic key_valid_i,
  input wire logic [7:0] key_code_i,
  input wire logic key_down_i,
  input wire logic key_held_i,
  input wire logic key_cursor_i,
  input wire logic key_modifier_i,
  // user actions
  output logic stimulus_o,
  output logic [2:0] stimulus_num_o,
  output logic response_o,
  output logic [2:0] response_num_o,
  output logic [1:0] repeat_mode_o
);
  typedef enum {ST_IDLE, ST_SEND, ST_ECHO} state_type;
  typedef enum {SRC_NONE, SRC_KEYS, SRC_REG, SRC_ID, SRC_NAME, SRC_STAT, SRC_EXT, SRC_CODE} src_type;

  function automatic logic in_range(input logic [7:0] op, input logic [7:0] lo, input logic [7:0] hi);
    in_range = (op >= lo) && (op <= hi);
  endfunction : in_range

  logic [7:0] regs [NREG];
  logic [7:0] next_regs [NREG];
  state_type state, next_state;
  src_type src, next_src;
  logic [3:0] idx, next_idx;
  logic [3:0] len, next_len;
  logic [7:0] echo, next_echo;
  logic [7:0] reg_sel, next_reg_sel;
  logic have_sel, next_have_sel;
  logic wr_pair, next_wr_pair;
  logic type2, next_type2;
  logic got_data, next_got_data;
  logic bad, next_bad;
  logic [7:0] pend_code, next_pend_code;
  logic pend, next_pend;
  logic held_valid, next_held_valid;
  logic [7:0] held_code, next_held_code;
  logic held_cursor, next_held_cursor;
  logic [31:0] rep_cnt, next_rep_cnt;
  logic [1:0] mode, next_mode;
  logic next_stim, next_resp;
  logic [2:0] next_stim_num, next_resp_num;
  logic d2h_valid, next_d2h_valid;
  logic d2h_cmd, next_d2h_cmd;
  logic [7:0] d2h_data, next_d2h_data;
  logic [7:0] out_byte;

  // no new host frame while an answer frame still stands on the loop
  assign link.h2d_ready = (state == ST_IDLE) && !d2h_valid;
  assign link.d2h_valid = d2h_valid;
  assign link.d2h_cmd = d2h_cmd;
  assign link.d2h_data = d2h_data;

  always_comb
  begin
    out_byte = 8'h00;
    case (src)
      SRC_KEYS: out_byte = pend_code;
      SRC_REG: out_byte = regs[reg_sel[3:0]];
      SRC_ID: out_byte = (idx == 4'h0) ? DEVICE_ID : {4'h0, idx};
      SRC_NAME: out_byte = 8'h41 + {4'h0, idx};
      SRC_STAT: out_byte = 8'h00;
      SRC_EXT: out_byte = {4'h0, idx};
      SRC_CODE: out_byte = 8'hC0 | {4'h0, idx};
      default: out_byte = 8'h00;
    endcase
  end

  always_comb
  begin
    for (int i = 0; i < NREG; i++) next_regs[i] = regs[i];
    next_state = state;
    next_src = src;
    next_idx = idx;
    next_len = len;
    next_echo = echo;
    next_reg_sel = reg_sel;
    next_have_sel = have_sel;
    next_wr_pair = wr_pair;
    next_type2 = type2;
    next_got_data = got_data;
    next_bad = bad;
    next_pend_code = pend_code;
    next_pend = pend;
    next_held_valid = held_valid;
    next_held_code = held_code;
    next_held_cursor = held_cursor;
    next_rep_cnt = rep_cnt;
    next_mode = mode;
    next_stim = 1'b0;
    next_resp = 1'b0;
    next_stim_num = stimulus_num_o;
    next_resp_num = response_num_o;
    next_d2h_valid = d2h_valid;
    next_d2h_cmd = d2h_cmd;
    next_d2h_data = d2h_data;
    // key capture and auto-repeat; one key per record, later keys are dropped while one is still pending
    if (key_valid_i && !key_modifier_i)
    begin
      next_held_valid = key_down_i && key_held_i;
      next_held_code = key_code_i;
      next_held_cursor = key_cursor_i;
      next_rep_cnt = 32'h0000_0000;
    end
    if (key_valid_i && !pend)
    begin
      next_pend = 1'b1;
      next_pend_code = key_code_i;
    end
    else if (held_valid && mode != 2'(link_cmd_pkg::REPEAT_OFF))
    begin
      next_rep_cnt = rep_cnt + 32'h0000_0001;
      if ((held_cursor && mode == 2'(link_cmd_pkg::REPEAT_FAST)) ? (rep_cnt >= 32'(FAST_CYC - 1))
          : (rep_cnt >= 32'(SLOW_CYC - 1)))
      begin
        next_rep_cnt = 32'h0000_0000;
        if (!pend)
        begin
          next_pend = 1'b1;
          next_pend_code = held_cursor ? link_cmd_pkg::KEY_CURSOR_REPEAT : held_code;
        end
      end
    end
    if (d2h_valid && link.d2h_ready)
      next_d2h_valid = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (link.h2d_valid && !link.h2d_cmd)
        begin
          // data frames are absorbed, never passed on
          next_got_data = 1'b1;
          if (type2 && have_sel)
          begin
            if (reg_sel[3:0] < NREG) next_regs[reg_sel[3:0]] = link.h2d_data;
          end
          else if (wr_pair)
          begin
            next_regs[reg_sel[3:0]] = link.h2d_data;
            next_wr_pair = 1'b0;
          end
          else
          begin
            next_reg_sel = {1'b0, link.h2d_data[6:0]};
            next_type2 = link.h2d_data[link_cmd_pkg::REG_TYPE2_BIT];
            next_have_sel = 1'b1;
            next_wr_pair = !link.h2d_data[link_cmd_pkg::REG_TYPE2_BIT];
            if (link.h2d_data[6:0] >= 7'(NREG)) next_bad = 1'b1;
          end
        end
        else if (link.h2d_valid && link.h2d_cmd)
        begin
          next_echo = link.h2d_data;
          next_idx = 4'h0;
          next_len = 4'h0;
          next_src = SRC_NONE;
          next_state = ST_ECHO;
          next_got_data = 1'b0;
          next_have_sel = 1'b0;
          next_wr_pair = 1'b0;
          next_type2 = 1'b0;
          next_bad = 1'b0;
          if (link.h2d_data == link_cmd_pkg::OP_REG_READ)
          begin
            // a read needs a type I number that is still waiting for its data
            if (!have_sel || type2 || !wr_pair || bad) next_echo = link_cmd_pkg::OP_REG_ERROR;
            else
            begin
              next_src = SRC_REG;
              next_len = 4'h1;
              next_state = ST_SEND;
            end
          end
          else if (link.h2d_data == link_cmd_pkg::OP_REG_WRITE)
          begin
            if (!have_sel || wr_pair || bad) next_echo = link_cmd_pkg::OP_REG_ERROR;
          end
          else if (got_data)
            next_echo = link_cmd_pkg::OP_REG_ERROR;
          else if (in_range(link.h2d_data, link_cmd_pkg::OP_COLLECT_BASE, link_cmd_pkg::OP_COLLECT_LAST))
          begin
            // room left is what the low bits still allow
            if (pend && link.h2d_data != link_cmd_pkg::OP_COLLECT_LAST)
            begin
              next_src = SRC_KEYS;
              next_len = 4'h1;
              next_state = ST_SEND;
            end
          end
          else if (link.h2d_data == link_cmd_pkg::OP_IDENTIFY)
          begin
            next_src = SRC_ID;
            next_len = 4'(link_cmd_pkg::IDENT_LEN + DESC_LEN);
            next_state = ST_SEND;
          end
          else if (link.h2d_data == link_cmd_pkg::OP_NAME)
          begin
            next_src = SRC_NAME;
            next_len = 4'(NAME_LEN);
            next_state = ST_SEND;
          end
          else if (link.h2d_data == link_cmd_pkg::OP_STATUS)
          begin
            next_src = SRC_STAT;
            next_len = 4'(STATUS_LEN);
            next_state = ST_SEND;
          end
          else if (link.h2d_data == link_cmd_pkg::OP_EXT_DESCRIBE)
          begin
            next_src = SRC_EXT;
            next_len = 4'(EXT_LEN);
            next_state = ST_SEND;
          end
          else if (link.h2d_data == link_cmd_pkg::OP_UNIQUE_CODE)
          begin
            next_src = SRC_CODE;
            next_len = 4'(CODE_LEN);
            next_state = ST_SEND;
          end
          else if (link.h2d_data == link_cmd_pkg::OP_REPEAT_OFF)
            next_mode = 2'(link_cmd_pkg::REPEAT_OFF);
          else if (link.h2d_data == link_cmd_pkg::OP_REPEAT_SLOW)
            next_mode = 2'(link_cmd_pkg::REPEAT_SLOW);
          else if (link.h2d_data == link_cmd_pkg::OP_REPEAT_FAST)
            next_mode = 2'(link_cmd_pkg::REPEAT_FAST);
        end
      end
      ST_SEND:
      begin
        if (!d2h_valid || link.d2h_ready)
        begin
          // data frames strictly before the echo, nothing in between
          next_d2h_valid = 1'b1;
          next_d2h_cmd = 1'b0;
          next_d2h_data = out_byte;
          next_idx = idx + 4'h1;
          if (src == SRC_KEYS) next_pend = 1'b0;
          if (idx + 4'h1 >= len) next_state = ST_ECHO;
        end
      end
      default:
      begin
        if (!d2h_valid || link.d2h_ready)
        begin
          next_d2h_valid = 1'b1;
          next_d2h_cmd = 1'b1;
          next_d2h_data = (src == SRC_KEYS) ? echo + {4'h0, len} : echo;
          next_state = ST_IDLE;
          // action in the same cycle the echo is put on the loop
          if (in_range(echo, link_cmd_pkg::OP_STIM_FIRST, link_cmd_pkg::OP_STIM_GENERAL))
          begin
            next_stim = 1'b1;
            next_stim_num = echo[2:0];
          end
          if (in_range(echo, link_cmd_pkg::OP_RESP_FIRST, link_cmd_pkg::OP_RESP_LAST))
          begin
            next_resp = 1'b1;
            next_resp_num = echo[2:0];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < NREG; i++) regs[i] <= 8'h00;
      state <= ST_IDLE;
      src <= SRC_NONE;
      idx <= 4'h0;
      len <= 4'h0;
      echo <= 8'h00;
      reg_sel <= 8'h00;
      have_sel <= 1'b0;
      wr_pair <= 1'b0;
      type2 <= 1'b0;
      got_data <= 1'b0;
      bad <= 1'b0;
      pend_code <= 8'h00;
      pend <= 1'b0;
      held_valid <= 1'b0;
      held_code <= 8'h00;
      held_cursor <= 1'b0;
      rep_cnt <= 32'h0000_0000;
      mode <= 2'(link_cmd_pkg::REPEAT_OFF);
      stimulus_o <= 1'b0;
      stimulus_num_o <= 3'h0;
      response_o <= 1'b0;
      response_num_o <= 3'h0;
      d2h_valid <= 1'b0;
      d2h_cmd <= 1'b0;
      d2h_data <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < NREG; i++) regs[i] <= next_regs[i];
      state <= next_state;
      src <= next_src;
      idx <= next_idx;
      len <= next_len;
      echo <= next_echo;
      reg_sel <= next_reg_sel;
      have_sel <= next_have_sel;
      wr_pair <= next_wr_pair;
      type2 <= next_type2;
      got_data <= next_got_data;
      bad <= next_bad;
      pend_code <= next_pend_code;
      pend <= next_pend;
      held_valid <= next_held_valid;
      held_code <= next_held_code;
      held_cursor <= next_held_cursor;
      rep_cnt <= next_rep_cnt;
      mode <= next_mode;
      stimulus_o <= next_stim;
      stimulus_num_o <= next_stim_num;
      response_o <= next_resp;
      response_num_o <= next_resp_num;
      d2h_valid <= next_d2h_valid;
      d2h_cmd <= next_d2h_cmd;
      d2h_data <= next_d2h_data;
    end
  end

  assign repeat_mode_o = mode;
endmodule : input_link_device_cmd_handler
`default_nettype wire

/* File: verilog/host_link_controller.sv */
// host end: sends one command sequence and collects the returned frames
`timescale 1ns/10ps
`default_nettype none
module host_link_controller (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // frame loop
  link_frame_if.host link,
  // user request
  input wire logic req_valid_i,
  input wire logic req_cmd_i,
  input wire logic [7:0] req_data_i,
  output logic req_ready_o,
  // returned frames
  output logic rsp_valid_o,
  output logic rsp_cmd_o,
  output logic [7:0] rsp_data_o
);
  logic h2d_valid, next_h2d_valid;
  logic h2d_cmd, next_h2d_cmd;
  logic [7:0] h2d_data, next_h2d_data;
  logic next_rsp_valid, next_rsp_cmd;
  logic [7:0] next_rsp_data;

  assign link.h2d_valid = h2d_valid;
  assign link.h2d_cmd = h2d_cmd;
  assign link.h2d_data = h2d_data;
  assign link.d2h_ready = 1'b1;
  assign req_ready_o = !h2d_valid;

  // the user keeps the order: register number before read/write, collect at 10h
  always_comb
  begin
    next_h2d_valid = h2d_valid;
    next_h2d_cmd = h2d_cmd;
    next_h2d_data = h2d_data;
    if (h2d_valid && link.h2d_ready)
      next_h2d_valid = 1'b0;
    else if (!h2d_valid && req_valid_i)
    begin
      next_h2d_valid = 1'b1;
      next_h2d_cmd = req_cmd_i;
      next_h2d_data = req_data_i;
    end
    next_rsp_valid = link.d2h_valid;
    next_rsp_cmd = link.d2h_cmd;
    next_rsp_data = link.d2h_data;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      h2d_valid <= 1'b0;
      h2d_cmd <= 1'b0;
      h2d_data <= 8'h00;
      rsp_valid_o <= 1'b0;
      rsp_cmd_o <= 1'b0;
      rsp_data_o <= 8'h00;
    end
    else
    begin
      h2d_valid <= next_h2d_valid;
      h2d_cmd <= next_h2d_cmd;
      h2d_data <= next_h2d_data;
      rsp_valid_o <= next_rsp_valid;
      rsp_cmd_o <= next_rsp_cmd;
      rsp_data_o <= next_rsp_data;
    end
  end
endmodule : host_link_controller
`default_nettype wire

/* File: test/link_frame_properties.sv */
// concurrent checks on the frame loop between the host and device ends
`timescale 1ns/10ps
`default_nettype none
module link_frame_properties #(
  parameter int DESC_LEN = 2,
  parameter int NAME_LEN = 8,
  parameter int STATUS_LEN = 1,
  parameter int EXT_LEN = link_cmd_pkg::EXT_DEFINED,
  parameter int CODE_LEN = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // host to device
  input wire logic h2d_valid,
  input wire logic h2d_cmd,
  input wire logic [7:0] h2d_data,
  input wire logic h2d_ready,
  // device to host
  input wire logic d2h_valid,
  input wire logic d2h_cmd,
  input wire logic [7:0] d2h_data,
  input wire logic d2h_ready
);
  logic cmd_take, echo_now, in_collect;
  logic [7:0] last_op, next_last_op;
  logic had_data, next_had_data, data_seen, next_data_seen;
  logic [4:0] data_cnt, next_data_cnt;
  assign cmd_take = h2d_valid && h2d_ready && h2d_cmd;
  assign echo_now = d2h_valid && d2h_cmd;
  assign in_collect = last_op >= link_cmd_pkg::OP_COLLECT_BASE && last_op <= link_cmd_pkg::OP_COLLECT_LAST;
  // remembers the last command and what preceded it, so each echo can be judged
  always_comb
  begin
    next_last_op = last_op;
    next_had_data = had_data;
    next_data_seen = data_seen;
    next_data_cnt = data_cnt;
    if (cmd_take)
    begin
      next_last_op = h2d_data;
      next_had_data = data_seen;
      next_data_seen = 1'b0;
      next_data_cnt = 5'h00;
    end
    else
    begin
      if (h2d_valid && h2d_ready)
        next_data_seen = 1'b1;
      if (d2h_valid && d2h_ready && !d2h_cmd)
        next_data_cnt = data_cnt + 5'h01;
    end
  end
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      last_op <= 8'h00;
      had_data <= 1'b0;
      data_seen <= 1'b0;
      data_cnt <= 5'h00;
    end
    else
    begin
      last_op <= next_last_op;
      had_data <= next_had_data;
      data_seen <= next_data_seen;
      data_cnt <= next_data_cnt;
    end
  end
  function automatic int rec_len(input logic [7:0] op);
    case (op)
      link_cmd_pkg::OP_IDENTIFY: rec_len = link_cmd_pkg::IDENT_LEN + DESC_LEN;
      link_cmd_pkg::OP_NAME: rec_len = NAME_LEN;
      link_cmd_pkg::OP_STATUS: rec_len = STATUS_LEN;
      link_cmd_pkg::OP_EXT_DESCRIBE: rec_len = EXT_LEN;
      link_cmd_pkg::OP_UNIQUE_CODE: rec_len = CODE_LEN;
      link_cmd_pkg::OP_REG_WRITE: rec_len = 0;
      default: rec_len = -1;
    endcase
  endfunction : rec_len
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_data_out;
    d2h_valid && !d2h_cmd;
  endsequence
  sequence s_echo(op);
    d2h_valid && d2h_cmd && d2h_data == op;
  endsequence
  chk_answer_prompt: assert property (cmd_take |-> ##2 d2h_valid)
    else $error("no answer frame two cycles after a command");
  chk_busy_refuses: assert property (d2h_valid |-> !h2d_ready)
    else $error("host frames accepted while answering");
  chk_write_quiet: assert property (h2d_valid && h2d_ready && !h2d_cmd |=> !d2h_valid)
    else $error("data frame passed back to the host");
  chk_read_reply: assert property (cmd_take && h2d_data == link_cmd_pkg::OP_REG_READ |-> ##2
    (s_data_out ##1 s_echo(link_cmd_pkg::OP_REG_READ)) or s_echo(link_cmd_pkg::OP_REG_ERROR))
    else $error("read not answered by one data frame and echo");
  chk_collect_count: assert property (echo_now && !had_data && in_collect |->
    d2h_data == last_op + 8'(data_cnt))
    else $error("collect echo not raised by frame count");
  chk_echo_same: assert property (echo_now && !had_data && !in_collect &&
    last_op != link_cmd_pkg::OP_REG_READ && last_op != link_cmd_pkg::OP_REG_WRITE |-> d2h_data == last_op)
    else $error("command not echoed unchanged");
  chk_error_opcode: assert property (echo_now && had_data && last_op != link_cmd_pkg::OP_REG_READ &&
    last_op != link_cmd_pkg::OP_REG_WRITE |-> d2h_data == link_cmd_pkg::OP_REG_ERROR)
    else $error("data then foreign command not answered by error opcode");
  chk_record_len: assert property (echo_now && rec_len(last_op) >= 0 && d2h_data == last_op |->
    int'(data_cnt) == rec_len(last_op))
    else $error("record length before echo is wrong");
endmodule : link_frame_properties
`default_nettype wire

/* File: test/tb_input_link_device_cmd_handler.sv */
// self-checking bench joining the host and device ends over the frame loop
`timescale 1ns/10ps
`default_nettype none
module tb_input_link_device_cmd_handler;
  // short repeat periods keep the run brief
  localparam int SLOW = 20;
  localparam int FAST = 10;
  localparam int DESC_LEN = 3;
  localparam int NAME_LEN = 15;
  localparam int CODE_LEN = 4;
  localparam logic [7:0] DEV_ID = 8'h3C; // arbitrary id value
  localparam int LIMIT = 20000;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic req_valid = 1'b0, req_cmd = 1'b0;
  logic [7:0] req_data = 8'h00, key_code = 8'h00, first_d;
  logic key_valid = 1'b0, key_down = 1'b0, key_held = 1'b0, key_cursor = 1'b0, key_modifier = 1'b0;
  logic req_ready, rsp_valid, rsp_cmd, stimulus, response;
  logic [7:0] rsp_data;
  logic [2:0] stimulus_num, response_num;
  logic [2:0] act_num = 3'h0;
  logic [1:0] repeat_mode;
  logic stim_seen = 1'b0, resp_seen = 1'b0;
  logic [8:0] rx_q[$];
  int error_cnt = 0, n_compared = 0, cycles = 0;
  link_frame_if link_frame_if_i ();
  input_link_device_cmd_handler #(.DESC_LEN(DESC_LEN), .NAME_LEN(NAME_LEN), .STATUS_LEN(1),
    .EXT_LEN(link_cmd_pkg::EXT_DEFINED), .CODE_LEN(CODE_LEN), .DEVICE_ID(DEV_ID), .SLOW_CYC(SLOW),
    .FAST_CYC(FAST)) input_link_device_cmd_handler_i (.clk_i(clk_i), .nrst_i(nrst_i), .link(link_frame_if_i),
    .key_valid_i(key_valid), .key_code_i(key_code), .key_down_i(key_down), .key_held_i(key_held),
    .key_cursor_i(key_cursor), .key_modifier_i(key_modifier), .stimulus_o(stimulus),
    .stimulus_num_o(stimulus_num), .response_o(response), .response_num_o(response_num),
    .repeat_mode_o(repeat_mode));
  host_link_controller host_link_controller_i (.clk_i(clk_i), .nrst_i(nrst_i), .link(link_frame_if_i),
    .req_valid_i(req_valid), .req_cmd_i(req_cmd), .req_data_i(req_data), .req_ready_o(req_ready),
    .rsp_valid_o(rsp_valid), .rsp_cmd_o(rsp_cmd), .rsp_data_o(rsp_data));
  link_frame_properties #(.DESC_LEN(DESC_LEN), .NAME_LEN(NAME_LEN), .STATUS_LEN(1),
    .EXT_LEN(link_cmd_pkg::EXT_DEFINED), .CODE_LEN(CODE_LEN)) link_frame_properties_i (.clk_i(clk_i),
    .nrst_i(nrst_i), .h2d_valid(link_frame_if_i.h2d_valid), .h2d_cmd(link_frame_if_i.h2d_cmd),
    .h2d_data(link_frame_if_i.h2d_data), .h2d_ready(link_frame_if_i.h2d_ready),
    .d2h_valid(link_frame_if_i.d2h_valid), .d2h_cmd(link_frame_if_i.d2h_cmd),
    .d2h_data(link_frame_if_i.d2h_data), .d2h_ready(link_frame_if_i.d2h_ready));
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic final_report();
    if (error_cnt == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report
  always @(posedge clk_i)
  begin
    cycles = cycles + 1;
    if (rsp_valid === 1'b1)
      rx_q.push_back({rsp_cmd, rsp_data});
    if (stimulus === 1'b1)
    begin
      stim_seen = 1'b1;
      act_num = stimulus_num;
    end
    if (response === 1'b1)
    begin
      resp_seen = 1'b1;
      act_num = response_num;
    end
    if (cycles == LIMIT)
    begin
      error_cnt = error_cnt + 1;
      final_report();
    end
  end
  task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp8
  task automatic send(input logic c, input logic [7:0] d);
    @(posedge clk_i);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_data <= d;
    @(posedge clk_i);
    while (req_ready !== 1'b1) @(posedge clk_i);
    req_valid <= 1'b0;
  endtask : send
  // nd below zero: any count, echo then expected as echo plus count
  task automatic xact(input logic [7:0] op, input int nd, input logic [7:0] echo);
    logic [8:0] f;
    int cnt;
    cnt = 0;
    f = 9'h000;
    first_d = 8'h00;
    send(1'b1, op);
    while (f[8] !== 1'b1)
    begin
      @(posedge clk_i);
      if (rx_q.size() > 0)
      begin
        f = rx_q.pop_front();
        if (f[8] !== 1'b1 && cnt == 0)
          first_d = f[7:0];
        if (f[8] !== 1'b1)
          cnt++;
      end
    end
    if (nd >= 0)
      cmp8("record length", 8'(nd), 8'(cnt));
    cmp8("echo", (nd < 0) ? echo + 8'(cnt) : echo, f[7:0]);
  endtask : xact
  task automatic press(input logic [7:0] code, input logic cur, input logic modk, input logic dn = 1'b1);
    @(posedge clk_i);
    key_valid <= 1'b1;
    key_code <= code;
    key_down <= dn;
    key_held <= dn;
    key_cursor <= cur;
    key_modifier <= modk;
    @(posedge clk_i);
    key_valid <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : press
  task automatic t_write_read();
    send(1'b0, 8'h03);
    send(1'b0, 8'hA5);
    xact(link_cmd_pkg::OP_REG_WRITE, 0, link_cmd_pkg::OP_REG_WRITE);
    send(1'b0, 8'h85);
    send(1'b0, 8'h11);
    send(1'b0, 8'h22);
    xact(link_cmd_pkg::OP_REG_WRITE, 0, link_cmd_pkg::OP_REG_WRITE);
    send(1'b0, 8'h03);
    xact(link_cmd_pkg::OP_REG_READ, 1, link_cmd_pkg::OP_REG_READ);
    cmp8("register 3", 8'hA5, first_d);
    send(1'b0, 8'h05);
    xact(link_cmd_pkg::OP_REG_READ, 1, link_cmd_pkg::OP_REG_READ);
    cmp8("register 5", 8'h22, first_d);
  endtask : t_write_read
  task automatic t_errors();
    xact(link_cmd_pkg::OP_REG_READ, 0, link_cmd_pkg::OP_REG_ERROR);
    send(1'b0, 8'h85);
    xact(link_cmd_pkg::OP_REG_READ, 0, link_cmd_pkg::OP_REG_ERROR);
    send(1'b0, 8'h02);
    xact(link_cmd_pkg::OP_REG_WRITE, 0, link_cmd_pkg::OP_REG_ERROR);
    send(1'b0, 8'h01);
    xact(link_cmd_pkg::OP_NAME, 0, link_cmd_pkg::OP_REG_ERROR);
    xact(8'h50, 0, 8'h50);
  endtask : t_errors
  task automatic t_records();
    xact(link_cmd_pkg::OP_IDENTIFY, link_cmd_pkg::IDENT_LEN + DESC_LEN, link_cmd_pkg::OP_IDENTIFY);
    cmp8("identity byte", DEV_ID, first_d);
    xact(link_cmd_pkg::OP_NAME, NAME_LEN, link_cmd_pkg::OP_NAME);
    xact(link_cmd_pkg::OP_STATUS, 1, link_cmd_pkg::OP_STATUS);
    xact(link_cmd_pkg::OP_EXT_DESCRIBE, link_cmd_pkg::EXT_DEFINED, link_cmd_pkg::OP_EXT_DESCRIBE);
    xact(link_cmd_pkg::OP_UNIQUE_CODE, CODE_LEN, link_cmd_pkg::OP_UNIQUE_CODE);
  endtask : t_records
  task automatic t_actions();
    for (int op = 8'h40; op <= 8'h4E; op++)
    begin
      stim_seen = 1'b0;
      resp_seen = 1'b0;
      xact(8'(op), 0, 8'(op));
      repeat (2) @(posedge clk_i);
      cmp8("stimulus seen", {7'h00, op <= 8'h47}, {7'h00, stim_seen});
      cmp8("response seen", {7'h00, op >= 8'h48}, {7'h00, resp_seen});
      cmp8("action number", {5'h00, 3'(op)}, {5'h00, act_num});
    end
  endtask : t_actions
  task automatic t_repeat();
    cmp8("repeat mode", 8'(link_cmd_pkg::REPEAT_OFF), {6'h00, repeat_mode});
    press(8'h21, 1'b0, 1'b0);
    xact(8'h10, 1, 8'h11);
    cmp8("key", 8'h21, first_d);
    repeat (3 * SLOW) @(posedge clk_i);
    xact(8'h10, 0, 8'h10);
    xact(link_cmd_pkg::OP_REPEAT_SLOW, 0, link_cmd_pkg::OP_REPEAT_SLOW);
    cmp8("repeat mode", 8'(link_cmd_pkg::REPEAT_SLOW), {6'h00, repeat_mode});
    repeat (3 * SLOW) @(posedge clk_i);
    xact(8'h10, 1, 8'h11);
    cmp8("repeated key", 8'h21, first_d);
    xact(link_cmd_pkg::OP_REPEAT_FAST, 0, link_cmd_pkg::OP_REPEAT_FAST);
    cmp8("repeat mode", 8'(link_cmd_pkg::REPEAT_FAST), {6'h00, repeat_mode});
    // a key-up event ends the repeat; it is reported once
    press(8'h21, 1'b0, 1'b0, 1'b0);
    xact(8'h10, 1, 8'h11);
    press(8'h4A, 1'b1, 1'b0);
    xact(8'h10, 1, 8'h11);
    repeat (3 * FAST) @(posedge clk_i);
    xact(8'h10, 1, 8'h11);
    cmp8("cursor repeat code", link_cmd_pkg::KEY_CURSOR_REPEAT, first_d);
    press(8'h4A, 1'b1, 1'b0, 1'b0);
    xact(8'h10, 1, 8'h11);
    press(8'h60, 1'b0, 1'b1);
    xact(8'h10, 1, 8'h11);
    repeat (3 * SLOW) @(posedge clk_i);
    xact(8'h10, 0, 8'h10);
    key_held <= 1'b0;
    xact(link_cmd_pkg::OP_REPEAT_OFF, 0, link_cmd_pkg::OP_REPEAT_OFF);
    cmp8("repeat mode", 8'(link_cmd_pkg::REPEAT_OFF), {6'h00, repeat_mode});
    // full count opcode leaves the key pending for the next request
    press(8'h33, 1'b0, 1'b0);
    xact(link_cmd_pkg::OP_COLLECT_LAST, 0, link_cmd_pkg::OP_COLLECT_LAST);
    xact(8'h10, 1, 8'h11);
    cmp8("held back key", 8'h33, first_d);
  endtask : t_repeat
  initial
  begin
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    t_repeat();
    t_write_read();
    t_errors();
    t_records();
    t_actions();
    final_report();
  end
endmodule : tb_input_link_device_cmd_handler
`default_nettype wire
